// ==== verilog/pgs_port.sv ====
// port a gpio with alternate pin steering, ahb-lite register slave
`timescale 1ns/10ps
// Summary of operation
// - eight independent pins, each with own direction, latch and read bit.
// - direction 1 makes input, 0 drives the latch onto the pin.
// - on every pin but 6, enabled peripheral takes the pin output; pin stays readable.
// - latch register write has the same effect as port register write.
// - latch read gives latch, port read gives pin levels.
// - port write stores the written data into the latch; the pin image is masked out.
// - direction keeps controlling the driver in analog mode.
// - analog-selected pins read 0 digitally.
// - analog select disables the pin's digital input buffer.
// - analog select never blocks digital output.
// - analog select bits reset to analog mode.
// - steer bit 1 puts timer three clock on b4 if 1, else b5.
// - steer bit 0 puts capture unit two on e7 if 1, else c1.
// - steering leaves directions alone; only the chosen pin is overridden.
// - on pin 6 clock output beats oscillator output beats latch.
// - analog bits exist only on pins 5 and 3..0; others read 0.
`include "pgs_cfg.svh"
module pgs_port (
  input  wire logic              core_clk,
  input  wire logic              reset_n,
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire pgs_pkg::pgs_trans_t htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic [31:0]       hwdata,
  input  wire logic              hready,
  output logic                   hreadyout,
  output logic [31:0]            hrdata,
  output logic                   hresp,
  input  wire logic [7:0]        pa_in,
  output logic [7:0]             pa_out,
  output logic [7:0]             pa_oe,
  output logic [7:0]             pa_ibuf_en,
  input  wire logic [7:0]        periph_en,
  input  wire logic [7:0]        periph_val,
  input  wire logic              clock_output_function_en,
  input  wire logic              clock_output_function_val,
  input  wire logic              osc_en,
  input  wire logic              osc_val,
  input  wire logic              pb4_in,
  input  wire logic              pb5_in,
  output logic                   tmr3_clk,
  input  wire logic              rc1_in,
  input  wire logic              re7_in,
  input  wire logic              capture_unit_two_oe,
  input  wire logic              capture_unit_two_val,
  output logic                   capture_unit_two_in,
  output logic                   rc1_ovr,
  output logic                   re7_ovr,
  output logic                   capture_unit_two_drv
);
  import pgs_pkg::*;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [`PGS_SYNC_W-1:0] s1_q, s2_q;
  logic [7:0]             pa_s;
  logic                   b4_s, b5_s, c1_s, e7_s;

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= {re7_in, rc1_in, pb5_in, pb4_in, pa_in};
      s2_q <= s1_q;
    end
  end
  assign pa_s = s2_q[7:0];
  assign b4_s = s2_q[8];
  assign b5_s = s2_q[9];
  assign c1_s = s2_q[10];
  assign e7_s = s2_q[11];

  //////////////////////////////////////////////////////////////////////
  // ahb-lite slave, one wait state per transfer
  pgs_bus_e    st_q, st_d;
  logic [7:0]  adr_q, adr_d;
  logic        wr_q, wr_d;
  logic        rdy_q, rdy_d;
  logic [31:0] rd_q, rd_d;
  logic        accept, wr_done;
  pgs_byte_t   pin_rd;

  pgs_byte_t   lat_q, lat_d, dir_q, dir_d, ans_q, ans_d;
  logic [1:0]  stv_q, stv_d;

  assign accept  = hsel && htrans[1] && hready;
  assign wr_done = (st_q == PGS_DATA) && wr_q && hready;
  assign pin_rd  = pa_s & ~ans_q;

  always_comb begin
    st_d  = st_q;
    adr_d = adr_q;
    wr_d  = wr_q;
    rdy_d = rdy_q;
    rd_d  = rd_q;
    case (st_q)
      PGS_IDLE, PGS_DATA: begin
        if (accept) begin
          st_d  = PGS_WAIT;
          adr_d = haddr[7:0];
          wr_d  = hwrite;
          rdy_d = 1'b0;
        end else begin
          st_d  = PGS_IDLE;
          rdy_d = 1'b1;
        end
      end
      PGS_WAIT: begin
        st_d  = PGS_DATA;
        rdy_d = 1'b1;
        rd_d  = 32'h0000_0000;
        if (!wr_q) begin
          case (adr_q)
            `PGS_OFS_LEVEL: rd_d[7:0] = pin_rd;
            `PGS_OFS_LATCH: rd_d[7:0] = lat_q;
            `PGS_OFS_DIR:   rd_d[7:0] = dir_q;
            `PGS_OFS_ANALOG_SELECT_BIT: rd_d[7:0] = ans_q & `PGS_ANS_MASK;
            `PGS_OFS_STEER: rd_d[1:0] = stv_q;
            default:        rd_d = 32'h0000_0000;
          endcase
        end
      end
      default: begin
        st_d  = PGS_IDLE;
        rdy_d = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      st_q  <= PGS_IDLE;
      adr_q <= 8'h00;
      wr_q  <= 1'b0;
      rdy_q <= 1'b1;
      rd_q  <= 32'h0000_0000;
    end else begin
      st_q  <= st_d;
      adr_q <= adr_d;
      wr_q  <= wr_d;
      rdy_q <= rdy_d;
      rd_q  <= rd_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // port registers
  always_comb begin
    lat_d = lat_q;
    dir_d = dir_q;
    ans_d = ans_q;
    stv_d = stv_q;
    if (wr_done) begin
      case (adr_q)
        // written data lands in the latch, pin image masked to zero
        `PGS_OFS_LEVEL: lat_d = (pin_rd & 8'h00) | hwdata[7:0];
        `PGS_OFS_LATCH: lat_d = hwdata[7:0];
        `PGS_OFS_DIR:   dir_d = hwdata[7:0];
        `PGS_OFS_ANALOG_SELECT_BIT: ans_d = hwdata[7:0] & `PGS_ANS_MASK;
        `PGS_OFS_STEER: stv_d = hwdata[1:0];
        default:        lat_d = lat_q;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      lat_q <= `PGS_LAT_RST;
      dir_q <= `PGS_DIR_RST;
      ans_q <= `PGS_ANS_RST;
      stv_q <= `PGS_STEER_RST;
    end else begin
      lat_q <= lat_d;
      dir_q <= dir_d;
      ans_q <= ans_d;
      stv_q <= stv_d;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // pin output muxes
  pgs_byte_t out_d, oe_d;
  logic      t3_d, cin_d, c1o_d, e7o_d, cdrv_d;

  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      if (gi == `PGS_PIN_CLK) begin : g_clk
        always_comb begin
          if (clock_output_function_en) begin
            out_d[gi] = clock_output_function_val;
            oe_d[gi]  = 1'b1;
          end else if (osc_en) begin
            out_d[gi] = osc_val;
            oe_d[gi]  = 1'b1;
          end else begin
            out_d[gi] = lat_q[gi];
            oe_d[gi]  = ~dir_q[gi];
          end
        end
      end else begin : g_gen
        always_comb begin
          if (periph_en[gi]) begin
            out_d[gi] = periph_val[gi];
            oe_d[gi]  = 1'b1;
          end else begin
            out_d[gi] = lat_q[gi];
            oe_d[gi]  = ~dir_q[gi];
          end
        end
      end
    end
  endgenerate

  always_comb begin
    t3_d   = stv_q[`PGS_STEER_T3] ? b4_s : b5_s;
    cin_d  = stv_q[`PGS_STEER_CCP] ? e7_s : c1_s;
    e7o_d  = stv_q[`PGS_STEER_CCP] && capture_unit_two_oe;
    c1o_d  = !stv_q[`PGS_STEER_CCP] && capture_unit_two_oe;
    cdrv_d = capture_unit_two_val;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      pa_out     <= 8'h00;
      pa_oe      <= 8'h00;
      pa_ibuf_en <= 8'h00;
      tmr3_clk   <= 1'b0;
      capture_unit_two_in    <= 1'b0;
      rc1_ovr    <= 1'b0;
      re7_ovr    <= 1'b0;
      capture_unit_two_drv   <= 1'b0;
      hresp      <= 1'b0;
    end else begin
      pa_out     <= out_d;
      pa_oe      <= oe_d;
      pa_ibuf_en <= ~ans_q;
      tmr3_clk   <= t3_d;
      capture_unit_two_in    <= cin_d;
      rc1_ovr    <= c1o_d;
      re7_ovr    <= e7o_d;
      capture_unit_two_drv   <= cdrv_d;
      hresp      <= 1'b0;
    end
  end

  assign hreadyout = rdy_q;
  assign hrdata    = rd_q;

  //////////////////////////////////////////////////////////////////////
  // checks
  sequence s_acc;
    accept && st_q != PGS_WAIT;
  endsequence
  sequence s_wait_done;
    !hreadyout ##1 hreadyout;
  endsequence

  bus_wait_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    s_acc |=> s_wait_done)
    else $error("transfer did not take exactly one wait state");

  lat_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_done && adr_q == `PGS_OFS_LATCH |=> lat_q == $past(hwdata[7:0]))
    else $error("latch write not stored");

  port_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_done && adr_q == `PGS_OFS_LEVEL |=> lat_q == $past(hwdata[7:0]))
    else $error("port write did not reach latch");

  analog_select_bit_read_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    st_q == PGS_WAIT && !wr_q && adr_q == `PGS_OFS_LEVEL
    |=> (hrdata[7:0] & $past(ans_q)) == 8'h00)
    else $error("analog pin read as nonzero");

  analog_select_bit_rsv_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    (ans_q & ~`PGS_ANS_MASK) == 8'h00)
    else $error("unimplemented analog bit set");

  analog_select_bit_rst_a: assert property (@(posedge core_clk)
    !reset_n |=> ans_q == `PGS_ANS_RST)
    else $error("analog select not reset to analog");

  drive_dir_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !clock_output_function_en && !osc_en && periph_en == 8'h00 ##1 $stable(dir_q)
    |-> pa_oe == ~dir_q)
    else $error("driver enable does not follow direction");

  clk_prio_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    clock_output_function_en |=> pa_oe[6] && pa_out[6] == $past(clock_output_function_val))
    else $error("clock output lost pin 6");

  osc_prio_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !clock_output_function_en && osc_en |=> pa_out[6] == $past(osc_val))
    else $error("oscillator output lost pin 6");

  steer_dir_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    wr_done && adr_q == `PGS_OFS_STEER |=> $stable(dir_q))
    else $error("steering changed direction");

  t3_route_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    stv_q[1] |=> tmr3_clk == $past(b4_s))
    else $error("timer three clock not from b4");

  ccp_route_a: assert property (@(posedge core_clk) disable iff (!reset_n)
    !stv_q[0] |=> !re7_ovr && capture_unit_two_in == $past(c1_s))
    else $error("capture unit two not on c1");
endmodule

// ==== common/pgs_cfg.svh ====
// constants for the port a pin steering block
`ifndef PGS_CFG_SVH
`define PGS_CFG_SVH
`define PGS_OFS_LEVEL   8'h00
`define PGS_OFS_LATCH   8'h04
`define PGS_OFS_DIR     8'h08
`define PGS_OFS_ANALOG_SELECT_BIT   8'h0c
`define PGS_OFS_STEER   8'h10
`define PGS_DIR_RST     8'hff
`define PGS_LAT_RST     8'h00
`define PGS_ANS_MASK    8'h2f
`define PGS_ANS_RST     8'h2f
`define PGS_STEER_RST   2'b00
`define PGS_STEER_T3    1
`define PGS_STEER_CCP   0
`define PGS_PIN_CLK     6
`define PGS_SYNC_W      12
`endif

// ==== common/pgs_pkg.sv ====
// types for the port a pin steering block
package pgs_pkg;
  typedef logic [1:0] pgs_trans_t;
  typedef logic [7:0] pgs_byte_t;
  typedef enum logic [1:0] {
    PGS_IDLE = 2'b00,
    PGS_WAIT = 2'b01,
    PGS_DATA = 2'b10
  } pgs_bus_e;
endpackage

// ==== tb/pgs_pins.sv ====
// pad-side model of the port a pins
`timescale 1ns/10ps
module pgs_pins (
  input  wire logic [7:0] pa_out,
  input  wire logic [7:0] pa_oe,
  input  wire logic [7:0] ext_lvl,
  output logic      [7:0] pa_in
);
  // a driven pad shows its driver, a released one the outside source
  assign pa_in = (pa_out & pa_oe) | (ext_lvl & ~pa_oe);
endmodule

// ==== tb/tb_port_a_gpio_with_pin_steering.sv ====
// self-checking bench for the port a pin steering block
`timescale 1ns/10ps
`include "pgs_cfg.svh"
module tb_port_a_gpio_with_pin_steering;
  import pgs_pkg::*;
  logic        core_clk = 0, reset_n = 0, hsel = 0, hwrite = 0;
  logic        clock_output_function_en = 0, clock_output_function_val = 0, osc_en = 0, osc_val = 0;
  logic        pb4_in = 0, pb5_in = 0, rc1_in = 0, re7_in = 0;
  logic        capture_unit_two_oe = 0, capture_unit_two_val = 0;
  logic        hready, hreadyout, hresp, tmr3_clk, capture_unit_two_in;
  logic        rc1_ovr, re7_ovr, capture_unit_two_drv;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, rd;
  pgs_trans_t  htrans = 2'b00;
  logic [2:0]  hsize = 3'b010;
  logic [7:0]  periph_en = 0, periph_val = 0, ext = 0;
  logic [7:0]  pa_in, pa_out, pa_oe, pa_ibuf_en;
  logic [7:0]  lat, dir, ans, v, e_oe, e_out;
  logic [15:0] seed = 16'he070;
  int          mismatches = 0, comparisons = 0;

  assign hready = hreadyout;
  always #2.5 core_clk = ~core_clk;

  pgs_port u_pgs_port (.core_clk, .reset_n, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp,
    .pa_in, .pa_out, .pa_oe, .pa_ibuf_en, .periph_en, .periph_val,
    .clock_output_function_en, .clock_output_function_val, .osc_en, .osc_val, .pb4_in, .pb5_in,
    .tmr3_clk, .rc1_in, .re7_in, .capture_unit_two_oe, .capture_unit_two_val, .capture_unit_two_in,
    .rc1_ovr, .re7_ovr, .capture_unit_two_drv);
  pgs_pins u_pgs_pins (.pa_out, .pa_oe, .ext_lvl(ext), .pa_in);

  //////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask

  // one single transfer, entered just after a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [7:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= {24'h0, wd};
    @(posedge core_clk);
    while (hready !== 1'b1) @(posedge core_clk);
    rd = hrdata;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d);
  endtask

  // idle first so pin changes clear the synchroniser
  task automatic rchk(input logic [7:0] a, input logic [7:0] e);
    repeat (4) @(posedge core_clk);
    bus(1'b0, a, 8'h00);
    chk(rd[7:0], e);
    chk(8'(|rd[31:8]), 8'h00);
    chk(8'(hresp), 8'h00);
  endtask

  task automatic end_sim;
    if (mismatches == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end

  initial begin
    repeat (4) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    lat = 8'h00;
    dir = 8'hff;
    rchk(`PGS_OFS_DIR, `PGS_DIR_RST);
    rchk(`PGS_OFS_LATCH, `PGS_LAT_RST);
    rchk(`PGS_OFS_ANALOG_SELECT_BIT, 8'h2f);
    rchk(`PGS_OFS_STEER, 8'h00);
    rchk(`PGS_OFS_LEVEL, 8'h00);
    chk(pa_ibuf_en, 8'hd0);
    chk(pa_oe, 8'h00);
    wr(`PGS_OFS_ANALOG_SELECT_BIT, 8'hff);
    rchk(`PGS_OFS_ANALOG_SELECT_BIT, 8'h2f);
    wr(8'h14, 8'h5a);
    rchk(8'h14, 8'h00);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      lat = seed[7:0];
      dir = seed[15:8];
      seed = lfsr(seed);
      ans = seed[7:0] & 8'h2f;
      ext <= seed[15:8];
      wr(i[0] ? `PGS_OFS_LATCH : `PGS_OFS_LEVEL, lat);
      wr(`PGS_OFS_DIR, dir);
      wr(`PGS_OFS_ANALOG_SELECT_BIT, seed[7:0]);
      rchk(`PGS_OFS_LATCH, lat);
      rchk(`PGS_OFS_DIR, dir);
      rchk(`PGS_OFS_ANALOG_SELECT_BIT, ans);
      rchk(`PGS_OFS_LEVEL, ((lat & ~dir) | (ext & dir)) & ~ans);
      chk(pa_oe, ~dir);
      chk(pa_out, lat);
      chk(pa_ibuf_en, ~ans);
    end
    capture_unit_two_oe <= 1'b1;
    for (int s = 0; s < 4; s++) begin
      seed = lfsr(seed);
      pb4_in <= seed[0];
      pb5_in <= ~seed[0];
      rc1_in <= seed[1];
      re7_in <= ~seed[1];
      capture_unit_two_val <= seed[2];
      wr(`PGS_OFS_STEER, 8'(s));
      rchk(`PGS_OFS_STEER, 8'(s));
      rchk(`PGS_OFS_DIR, dir);
      chk(8'(tmr3_clk), 8'(s[1] ? pb4_in : pb5_in));
      chk(8'(capture_unit_two_in), 8'(s[0] ? re7_in : rc1_in));
      chk({6'h0, re7_ovr, rc1_ovr}, {6'h0, s[0], ~s[0]});
      chk(8'(capture_unit_two_drv), 8'(capture_unit_two_val));
    end
    wr(`PGS_OFS_ANALOG_SELECT_BIT, 8'h00);
    periph_en <= 8'h01;
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      v = seed[7:0];
      clock_output_function_en <= k[1];
      osc_en <= k[0];
      clock_output_function_val <= v[2];
      osc_val <= v[3];
      periph_val <= v;
      e_oe = ~dir | 8'h01 | {1'b0, k[1] | k[0], 6'h0};
      e_out = {lat[7], k[1] ? v[2] : k[0] ? v[3] : lat[6], lat[5:1], v[0]};
      rchk(`PGS_OFS_LEVEL, (e_out & e_oe) | (ext & ~e_oe));
      chk(pa_oe, e_oe);
      chk(pa_out, e_out);
    end
    end_sim();
  end
endmodule
